// >>> design/s_interface_activation_fsm.sv
// Layer-1 activation and deactivation state machine with APB configuration.
`timescale 1ns/1ns
module s_interface_activation_fsm
  import s_act_pkg::*;
(
  // Clock, reset and clock enable.
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        ce,
  // APB slave.
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  // Command and indication channel, same clock as the controller.
  input  wire logic [3:0]  cmd_code,
  output logic      [3:0]  ind_code,
  // Line receiver status, asynchronous to pclk.
  input  wire line_rx_t    line_rx,
  // Line transmit control.
  output line_tx_t         line_tx
);

  state_t      state_q;
  state_t      state_d;
  logic [31:0] config_q;
  line_rx_t    rx_sync;
  line_rx_t    rx;
  logic [15:0] frame_cnt_q;
  logic        frame_tick;
  logic [3:0]  cmd_q;
  logic [7:0]  info0_cnt_q;
  logic [7:0]  deact_cnt_q;
  logic        info0_done;
  logic        deact_done;
  logic        cvr_q;
  logic        tr_off;
  logic        tx_off;
  logic        lt_mode;
  logic        loop_q;
  logic        cont_q;
  logic        apb_wr;
  logic        apb_rd;

  assign tr_off  = config_q[CFG_TR_OFF_BIT];
  assign tx_off  = config_q[CFG_TX_OFF_BIT];
  assign lt_mode = config_q[CFG_LT_BIT];

  // Line status bits come from the analog clock, so each is synchronised.
  sync3 #(.W($bits(line_rx_t))) u_rx_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .ce      (ce),
    .din     (line_rx),
    .dout    (rx_sync)
  );

  // Line inputs are forced idle while clearing or while layer 1 is off.
  always_comb
  begin
    rx = rx_sync;
    if (tr_off || cmd_q == CMD_FSM_CLEAR)
      rx = '0;
  end

  // Frame tick divides pclk down to the 4 kHz frame rate.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      frame_cnt_q <= '0;
    else if (ce)
      frame_cnt_q <= frame_tick ? '0 : frame_cnt_q + 16'h0001;
  end
  assign frame_tick = (frame_cnt_q == 16'(FRAME_CYC - 1));

  // Command code is sampled once per frame; undefined codes do nothing.
  // It resets to the confirm code, so the machine leaves its reset state
  // on its own and comes up deactivated without help from the controller.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cmd_q <= CMD_DEACT_CONF;
    else if (ce && frame_tick)
      cmd_q <= cmd_code;
  end

  // Deactivation timers counted in frames: INFO 0 run and overall limit.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      info0_cnt_q <= '0;
      deact_cnt_q <= '0;
    end
    else if (ce)
    begin
      if (state_q != ST_PEND_DEA)
      begin
        info0_cnt_q <= '0;
        deact_cnt_q <= '0;
      end
      else if (frame_tick)
      begin
        deact_cnt_q <= deact_cnt_q + 8'h01;
        info0_cnt_q <= rx.info0 ? info0_cnt_q + 8'h01 : 8'h00;
      end
    end
  end
  assign info0_done = (info0_cnt_q >= 8'(INFO0_FRAMES));
  assign deact_done = (deact_cnt_q >= 8'(DEACT_FRAMES));

  // Next state logic for both termination variants.
  always_comb
  begin
    state_d = state_q;
    unique case (state_q)
      ST_RESET:
        if (cmd_q == CMD_DEACT_CONF)
          state_d = ST_DEACT;
      ST_DEACT:
        if (!lt_mode && rx.level && !rx.info0)
          state_d = ST_DETECTED;
        else if (lt_mode && (rx.level || cmd_q == CMD_ACT_REQ
                 || cmd_q == CMD_LOOP_REQ))
          state_d = ST_PEND_ACT;
        else if (!lt_mode && (cmd_q == CMD_ACT_REQ
                 || cmd_q == CMD_LOOP_REQ))
          state_d = ST_PEND_ACT;
      ST_DETECTED:
        if (cmd_q == CMD_ACT_REQ || cmd_q == CMD_LOOP_REQ)
          state_d = ST_PEND_ACT;
      ST_PEND_ACT:
        if (rx.info3)
          state_d = lt_mode ? ST_ACTIVE : ST_WAIT_SW;
      ST_WAIT_SW:
        if (cmd_q == CMD_SWITCH || cmd_q == CMD_LOOP_IND)
          state_d = ST_ACTIVE;
      ST_ACTIVE:
        if (!rx.synced)
          state_d = ST_LOST_LINE;
        else if (!lt_mode && cmd_q == CMD_UNSYNCED)
          state_d = ST_LOST_UP;
      ST_LOST_LINE:
        if (rx.info3 && rx.synced)
          state_d = lt_mode ? ST_ACTIVE : ST_WAIT_SW;
      ST_LOST_UP:
        if (cmd_q == CMD_SWITCH || cmd_q == CMD_LOOP_IND)
          state_d = ST_ACTIVE;
      ST_PEND_DEA:
        if (info0_done || deact_done)
          state_d = ST_WAIT_DC;
      ST_WAIT_DC:
        if (cmd_q == CMD_DEACT_CONF)
          state_d = ST_DEACT;
      ST_TEST:
        if (cmd_q == CMD_DEACT_CONF)
          state_d = ST_DEACT;
      default:
        state_d = ST_RESET;
    endcase
    // Deactivation request applies in all active-going states.
    if (cmd_q == CMD_DEACT_REQ && state_q != ST_RESET
        && state_q != ST_DEACT && state_q != ST_WAIT_DC
        && state_q != ST_PEND_DEA)
      state_d = ST_PEND_DEA;
    // Test codes enter test mode from any state but test mode itself.
    if ((cmd_q == CMD_SINGLE_TEST || cmd_q == CMD_CONT_TEST)
        && state_q != ST_TEST)
      state_d = ST_TEST;
    // Clear and layer-1 off override everything.
    if (cmd_q == CMD_FSM_CLEAR || tr_off)
      state_d = ST_RESET;
  end

  // State register.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      state_q <= ST_RESET;
    else if (ce)
      state_q <= state_d;
  end

  // Loop closure is latched by the loop commands and opened on leaving.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      loop_q <= 1'b0;
    else if (ce)
    begin
      if (state_d == ST_DEACT || state_d == ST_RESET
          || state_d == ST_PEND_DEA || state_d == ST_TEST)
        loop_q <= 1'b0;
      else if (cmd_q == CMD_LOOP_REQ && state_q != ST_ACTIVE)
        loop_q <= 1'b1;
      else if (cmd_q == CMD_LOOP_IND && state_q == ST_ACTIVE
               && !lt_mode)
        loop_q <= 1'b1;
    end
  end

  // The pulse pattern is latched on entry to test mode: the controller
  // releases the code once the mode has started, and the line must not
  // fall back to single pulses when it does.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cont_q <= 1'b0;
    else if (ce && state_q != ST_TEST)
      cont_q <= (cmd_q == CMD_CONT_TEST);
  end

  // Code violations are held until the next frame tick so the controller can see them.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      cvr_q <= 1'b0;
    else if (ce)
    begin
      if (rx.code_viol && config_q[CFG_CVR_EN_BIT])
        cvr_q <= 1'b1;
      else if (frame_tick)
        cvr_q <= 1'b0;
    end
  end

  // Indications always follow the present state.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      ind_code <= IND_WAIT;
    else if (ce)
    begin
      unique case (state_q)
        ST_RESET:     ind_code <= IND_WAIT;
        ST_DEACT:     ind_code <= (lt_mode && rx.level) ? IND_WAIT
                                                       : IND_DEACTIVATED;
        ST_DETECTED:  ind_code <= IND_ACT_REQ;
        ST_PEND_ACT:  ind_code <= IND_ACT_REQ;
        ST_WAIT_SW:   ind_code <= IND_ACT_REQ;
        ST_ACTIVE:    ind_code <= cvr_q ? IND_CODE_VIOL
                                        : IND_ACTIVE;
        ST_LOST_LINE: ind_code <= IND_UNSYNCED;
        ST_LOST_UP:   ind_code <= IND_UNSYNCED;
        ST_PEND_DEA:  ind_code <= IND_WAIT;
        ST_WAIT_DC:   ind_code <= IND_DEACTIVATED;
        ST_TEST:      ind_code <= IND_WAIT;
        default:      ind_code <= IND_WAIT;
      endcase
    end
  end

  // Transmit selection, driver enables and channel switching.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      line_tx <= '0;
    else if (ce)
    begin
      unique case (state_q)
        ST_PEND_ACT,
        ST_WAIT_SW,
        ST_LOST_LINE,
        ST_LOST_UP:   line_tx.info <= TX_INFO2;
        ST_ACTIVE:    line_tx.info <= TX_INFO4;
        ST_TEST:      line_tx.info <= cont_q ? TX_CONT
                                             : TX_SINGLE;
        default:      line_tx.info <= TX_INFO0;
      endcase
      line_tx.tx_enable   <= !tx_off && !tr_off;
      line_tx.rx_enable   <= !tr_off;
      line_tx.loop_closed <= loop_q;
      line_tx.transparent <= (state_q == ST_ACTIVE);
    end
  end

  // APB: zero wait states, unmapped addresses answer with an error.
  assign pready = 1'b1;
  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;

  // Errors are flagged in the access phase only, so a setup cycle that is
  // still decoding its address never shows a stale error to the master.
  always_comb
  begin
    pslverr = 1'b0;
    if (psel && penable && paddr != ADDR_CONFIG && paddr != ADDR_STATUS)
      pslverr = 1'b1;
  end

  // Config register; the transmitter starts disabled.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      config_q <= CONFIG_RESET;
    else if (ce && apb_wr && paddr == ADDR_CONFIG)
      config_q <= pwdata & 32'h0000_000f;
  end

  // Read data is registered in the setup phase for the access phase.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      prdata <= '0;
    else if (ce && apb_rd && !penable)
    begin
      if (paddr == ADDR_CONFIG)
        prdata <= config_q;
      else if (paddr == ADDR_STATUS)
        prdata <= {12'h000, 5'(rx), 4'(ind_code), 11'(state_q)};
      else
        prdata <= '0;
    end
  end

endmodule : s_interface_activation_fsm

// >>> design/s_act_pkg.sv
// Package with constants, types and register map for the activation machine.
package s_act_pkg;

  // Command codes from the upstream controller.
  localparam logic [3:0] CMD_DEACT_REQ   = 4'h0;
  localparam logic [3:0] CMD_FSM_CLEAR   = 4'h1;
  localparam logic [3:0] CMD_SINGLE_TEST = 4'h2;
  localparam logic [3:0] CMD_CONT_TEST   = 4'h3;
  localparam logic [3:0] CMD_UNSYNCED    = 4'h4;
  localparam logic [3:0] CMD_ACT_REQ     = 4'h8;
  localparam logic [3:0] CMD_LOOP_REQ    = 4'ha;
  localparam logic [3:0] CMD_SWITCH      = 4'hc;
  localparam logic [3:0] CMD_LOOP_IND    = 4'he;
  localparam logic [3:0] CMD_DEACT_CONF  = 4'hf;

  // Indication codes towards the upstream controller.
  localparam logic [3:0] IND_WAIT        = 4'h0;
  localparam logic [3:0] IND_UNSYNCED    = 4'h4;
  localparam logic [3:0] IND_ACT_REQ     = 4'h8;
  localparam logic [3:0] IND_CODE_VIOL   = 4'hb;
  localparam logic [3:0] IND_ACTIVE      = 4'hc;
  localparam logic [3:0] IND_DEACTIVATED = 4'hf;

  // Line signal selection driven towards the analog front end.
  localparam logic [2:0] TX_INFO0        = 3'h0;
  localparam logic [2:0] TX_INFO2        = 3'h2;
  localparam logic [2:0] TX_INFO4        = 3'h4;
  localparam logic [2:0] TX_SINGLE       = 3'h5;
  localparam logic [2:0] TX_CONT         = 3'h6;

  // APB register byte addresses.
  localparam logic [11:0] ADDR_CONFIG    = 12'h000;
  localparam logic [11:0] ADDR_STATUS    = 12'h004;
  localparam logic [11:0] ADDR_MASK      = 12'hffc;

  // Config register fields and reset value.
  localparam int          CFG_TR_OFF_BIT = 0;
  localparam int          CFG_TX_OFF_BIT = 1;
  localparam int          CFG_CVR_EN_BIT = 2;
  localparam int          CFG_LT_BIT     = 3;
  localparam logic [31:0] CONFIG_RESET   = 32'h0000_0002;

  // Timing: frame period 250 us, the device clock is 25 MHz.
  localparam int          CLK_HZ         = 25_000_000;
  localparam int          FRAME_US       = 250;
  localparam int          INFO0_MS       = 16;
  localparam int          DEACT_MS       = 32;
  localparam int          FRAME_CYC      = CLK_HZ / 1_000_000 * FRAME_US;
  localparam int          INFO0_FRAMES   = INFO0_MS * 1000 / FRAME_US;
  localparam int          DEACT_FRAMES   = DEACT_MS * 1000 / FRAME_US;

  // States, one-hot.
  typedef enum logic [10:0] {
    ST_RESET     = 11'h001,
    ST_DEACT     = 11'h002,
    ST_DETECTED  = 11'h004,
    ST_PEND_ACT  = 11'h008,
    ST_WAIT_SW   = 11'h010,
    ST_ACTIVE    = 11'h020,
    ST_LOST_LINE = 11'h040,
    ST_LOST_UP   = 11'h080,
    ST_PEND_DEA  = 11'h100,
    ST_WAIT_DC   = 11'h200,
    ST_TEST      = 11'h400
  } state_t;

  // Receiver status from the line front end.
  typedef struct packed {
    logic info0;
    logic level;
    logic info3;
    logic synced;
    logic code_viol;
  } line_rx_t;

  // Transmit control towards the line front end.
  typedef struct packed {
    logic [2:0] info;
    logic       tx_enable;
    logic       rx_enable;
    logic       loop_closed;
    logic       transparent;
  } line_tx_t;

endpackage : s_act_pkg

// >>> design/sync3.sv
// Three-stage synchroniser with agreement filter on the last two stages.
`timescale 1ns/1ns
module sync3
  import s_act_pkg::*;
#(
  parameter int W = 1
)
(
  // Clock and reset.
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic         ce,
  // Data.
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end
    else if (ce)
    begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // A change is taken only once stages two and three agree.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
      dout <= '0;
    else if (ce && (s2_q == s3_q))
      dout <= s3_q;
  end

endmodule : sync3

// >>> test/s_act_props.sv
// Port checker for the activation machine, bound to its top module.
`timescale 1ns/1ns
module s_act_props
  import s_act_pkg::*;
(
  // Clock and reset.
  input wire logic       pclk,
  input wire logic       presetn,
  // Command and line side.
  input wire logic [3:0] cmd_code,
  input wire logic [3:0] ind_code,
  input wire line_tx_t   line_tx
);
  // Two frames plus slack: a command must have acted by then.
  localparam int HOLD = 2 * FRAME_CYC + 8;
  logic [14:0] held_q;
  logic [3:0]  last_q;

  // Count how long the command has stood; any change restarts it.
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      held_q <= 15'h0;
      last_q <= 4'h0;
    end
    else
    begin
      last_q <= cmd_code;
      if (cmd_code != last_q)
        held_q <= 15'h0;
      else if (held_q != 15'(HOLD))
        held_q <= held_q + 15'h1;
    end
  end

  default clocking @(posedge pclk);
  endclocking
  default disable iff (!presetn);

  sequence held_cmd(logic [3:0] c);
    held_q == 15'(HOLD) && cmd_code == c;
  endsequence

  chk_clear_info0:
  assert property (held_cmd(CMD_FSM_CLEAR) |->
    (line_tx.info == TX_INFO0 && ind_code == IND_WAIT)[*4])
    else $error("clear did not give idle line and wait");
  chk_single_pulse:
  assert property (held_cmd(CMD_SINGLE_TEST) |->
    line_tx.info == TX_SINGLE ##1 $stable(line_tx.info))
    else $error("single pulse test not sent");
  chk_cont_pulse:
  assert property (held_cmd(CMD_CONT_TEST) |-> line_tx.info == TX_CONT)
    else $error("continuous pulse test not sent");
  chk_deact_silent:
  assert property (held_cmd(CMD_DEACT_REQ) |->
    line_tx.info != TX_INFO2 && line_tx.info != TX_INFO4)
    else $error("deactivation still sends signal");
  chk_active_info4:
  assert property (ind_code == IND_ACTIVE |-> line_tx.info == TX_INFO4)
    else $error("active indication without info4");
  chk_transp_info4:
  assert property (line_tx.transparent |-> line_tx.info == TX_INFO4)
    else $error("transparent outside info4");
  chk_info2_closed:
  assert property (line_tx.info == TX_INFO2 |-> !line_tx.transparent)
    else $error("transparent while sending info2");
  chk_idle_closed:
  assert property (line_tx.info == TX_INFO0 |-> !line_tx.transparent)
    else $error("transparent while line idle");
endmodule : s_act_props

bind s_interface_activation_fsm s_act_props chk (
  .pclk(pclk), .presetn(presetn), .cmd_code(cmd_code),
  .ind_code(ind_code), .line_tx(line_tx));

// >>> test/upstream_model.sv
// Upstream controller model that holds each command code for two frames.
`timescale 1ns/1ns
module upstream_model
  import s_act_pkg::*;
(
  // Clock and reset.
  input  wire logic       pclk,
  input  wire logic       presetn,
  // Requests from the bench.
  input  wire logic       go,
  input  wire logic [3:0] code,
  output logic            busy,
  // Command channel.
  output logic      [3:0] cmd_code
);
  localparam int HOLD_CYC = 2 * FRAME_CYC + 10;
  int left;

  // Releasing early could let a frame sample miss the command entirely.
  always @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      cmd_code <= 4'h9;
      busy <= 1'b0;
      left = 0;
    end
    else if (go && !busy)
    begin
      cmd_code <= code;
      busy <= 1'b1;
      left = HOLD_CYC;
    end
    else if (busy)
    begin
      left = left - 1;
      if (left == 0)
      begin
        cmd_code <= 4'(5 + $urandom % 3);
        busy <= 1'b0;
      end
    end
  end
endmodule : upstream_model

// >>> test/s_interface_activation_fsm_bench.sv
// Self-checking bench for the activation machine.
`timescale 1ns/1ns
module s_interface_activation_fsm_bench
  import s_act_pkg::*;
;
  typedef struct {
    string       what;
    logic [1:0]  sel;
    logic [32:0] exp;
    logic [32:0] mask;
  } note_t;
  logic        pclk;
  logic        presetn;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [3:0]  cmd_code;
  logic [3:0]  ind_code;
  line_rx_t    line_rx;
  line_tx_t    line_tx;
  logic        go;
  logic [3:0]  code;
  logic        busy;
  logic        look;
  int          errors;
  int          num_checks;
  note_t       notes[$];

  s_interface_activation_fsm uut (.pclk(pclk), .presetn(presetn),
    .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .cmd_code(cmd_code), .ind_code(ind_code),
    .line_rx(line_rx), .line_tx(line_tx));
  upstream_model ctrl (.pclk(pclk), .presetn(presetn), .go(go),
    .code(code), .busy(busy), .cmd_code(cmd_code));

  // Free-running 25 MHz clock.
  initial pclk = 1'b0;
  always #20 pclk = ~pclk;

  // Each read completion or look strobe takes the oldest note.
  always @(posedge pclk)
  begin
    note_t       cur;
    logic [32:0] got;
    if ((psel && penable && pready === 1'b1 && !pwrite) || look)
    begin
      cur = notes.pop_front();
      got = cur.sel == 2'd0 ? {pslverr, prdata}
          : cur.sel == 2'd1 ? {29'h0, ind_code} : {26'h0, line_tx};
      num_checks++;
      if ((got & cur.mask) !== (cur.exp & cur.mask))
      begin
        errors++;
        $display("[FAIL] %s expected %h seen %h", cur.what,
                 cur.exp & cur.mask, got & cur.mask);
      end
    end
  end

  task automatic note(string w, logic [1:0] s, logic [32:0] e,
                      logic [32:0] m);
    notes.push_back('{w, s, e, m});
  endtask : note

  task automatic look_at(string w, logic [1:0] s, logic [32:0] e,
                         logic [32:0] m);
    note(w, s, e, m);
    look <= 1'b1;
    @(posedge pclk);
    look <= 1'b0;
    @(posedge pclk);
  endtask : look_at

  task automatic stuck(string w);
    errors++;
    $display("[FAIL] %s expected done seen timeout", w);
    close_out();
  endtask : stuck

  // One APB transfer; the request stands until pready is seen high.
  task automatic apb(logic wr, logic [11:0] a, logic [31:0] d);
    int n;
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (pready !== 1'b1 && n < 20);
    if (n >= 20)
      stuck("apb");
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge pclk);
  endtask : apb

  task automatic send(logic [3:0] c);
    int n;
    code <= c;
    go <= 1'b1;
    @(posedge pclk);
    go <= 1'b0;
    n = 0;
    do
    begin
      @(posedge pclk);
      n++;
    end
    while (busy === 1'b1 && n < 3 * FRAME_CYC);
    if (n >= 3 * FRAME_CYC)
      stuck("command");
  endtask : send

  task automatic close_out();
    $display("checks %0d errors %0d", num_checks, errors);
    if (errors == 0 && num_checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : close_out

  // Main sequence: registers, activation, deactivation, test modes.
  initial
  begin
    int n;
    errors = 0;
    num_checks = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, go, look} = 5'h0;
    paddr = 12'h0;
    pwdata = 32'h0;
    code = 4'h0;
    line_rx = line_rx_t'(5'h00);
    void'($urandom(32'ha79e));
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    note("config reset", 0, {1'b0, CONFIG_RESET}, '1);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    apb(1'b1, ADDR_CONFIG, 32'h4);
    note("config", 0, 33'h4, 33'h1_0000_000f);
    apb(1'b0, ADDR_CONFIG, 32'h0);
    note("unmapped", 0, 33'h1_0000_0000, '1);
    apb(1'b0, 12'h008, 32'h0);
    $display("test registers done");
    // Exchange side: line-driven activation, lost sync, code violation.
    apb(1'b1, ADDR_CONFIG, 32'hc);
    line_rx <= line_rx_t'(5'h08);
    repeat (8) @(posedge pclk);
    look_at("lt pending tx", 2, {26'h0, TX_INFO2, 4'h0}, 33'h71);
    line_rx <= line_rx_t'(5'h0f);
    repeat (8) @(posedge pclk);
    look_at("lt active tx", 2, {26'h0, TX_INFO4, 4'hd}, 33'h7f);
    look_at("lt viol ind", 1, {29'h0, IND_CODE_VIOL}, 33'hf);
    line_rx <= line_rx_t'(5'h0c);
    repeat (8) @(posedge pclk);
    look_at("lt lost tx", 2, {26'h0, TX_INFO2, 4'h0}, 33'h71);
    look_at("lt lost ind", 1, {29'h0, IND_UNSYNCED}, 33'hf);
    line_rx <= line_rx_t'(5'h0e);
    repeat (8) @(posedge pclk);
    look_at("lt resume tx", 2, {26'h0, TX_INFO4, 4'h1}, 33'h71);
    line_rx <= line_rx_t'(5'h00);
    apb(1'b1, ADDR_CONFIG, 32'h1);
    repeat (2) @(posedge pclk);
    look_at("off tx", 2, 33'h0, 33'h7f);
    apb(1'b1, ADDR_CONFIG, 32'h4);
    $display("test exchange side done");
    send(CMD_DEACT_CONF);
    look_at("deact tx", 2, {26'h0, TX_INFO0, 4'h0}, 33'h71);
    line_rx <= line_rx_t'(5'h08);
    n = 0;
    while (ind_code !== IND_ACT_REQ && n < 2 * FRAME_CYC)
    begin
      @(posedge pclk);
      n++;
    end
    if (n >= 2 * FRAME_CYC)
      stuck("detect");
    look_at("detect ind", 1, {29'h0, IND_ACT_REQ}, 33'hf);
    send(CMD_ACT_REQ);
    look_at("pending tx", 2, {26'h0, TX_INFO2, 4'h0}, 33'h71);
    line_rx <= line_rx_t'(5'h0e);
    repeat (FRAME_CYC + 8) @(posedge pclk);
    look_at("wait tx", 2, {26'h0, TX_INFO2, 4'h0}, 33'h71);
    send(CMD_SWITCH);
    look_at("active tx", 2, {26'h0, TX_INFO4, 4'hd}, 33'h7f);
    look_at("active ind", 1, {29'h0, IND_ACTIVE}, 33'hf);
    note("status", 0, {18'h0, IND_ACTIVE, ST_ACTIVE}, 33'h7fff);
    apb(1'b0, ADDR_STATUS, 32'h0);
    $display("test activation done");
    send(CMD_DEACT_REQ);
    line_rx <= line_rx_t'(5'h10);
    look_at("deact req tx", 2, {26'h0, TX_INFO0, 4'h0}, 33'h70);
    look_at("deact req ind", 1, {29'h0, IND_WAIT}, 33'hf);
    $display("test deactivation done");
    send(CMD_SINGLE_TEST);
    look_at("single tx", 2, {26'h0, TX_SINGLE, 4'h0}, 33'h70);
    send(CMD_FSM_CLEAR);
    look_at("clear tx", 2, {26'h0, TX_INFO0, 4'h0}, 33'h70);
    look_at("clear ind", 1, {29'h0, IND_WAIT}, 33'hf);
    send(CMD_CONT_TEST);
    look_at("cont tx", 2, {26'h0, TX_CONT, 4'h0}, 33'h70);
    $display("test pulse modes done");
    close_out();
  end
endmodule : s_interface_activation_fsm_bench
